// ---- common/timer_unit_params.svh ----
// Named constants of the 16-bit timer/counter control block.
// Assumes inclusion by bare name from common/ on the include path.
`ifndef TIMER_UNIT_PARAMS_SVH
`define TIMER_UNIT_PARAMS_SVH
// Register indices; the byte address on the bus is four times the index.
`define TU_IDX_CTRL 8'h0F
`define TU_IDX_CMP_LO 8'h10
`define TU_IDX_CMP_HI 8'h11
`define TU_IDX_CAP_LO 8'h12
`define TU_IDX_CAP_HI 8'h13
`define TU_IDX_STATUS 8'h14
// Control register fields and reset values.
`define TU_CTRL_RESET 8'h00
`define TU_TIMER_RESET 16'hFFFF
`define TU_BIT_FLIPFLOP 7
`define TU_BIT_OPTION 6
`define TU_START_HI 5
`define TU_START_LO 4
`define TU_CLK_HI 3
`define TU_CLK_LO 2
`define TU_MODE_HI 1
`define TU_MODE_LO 0
// Prescaler taps: divisor 2^(tap+1), one more when the prescale flag is set.
`define TU_PRESCALE_W 13
`define TU_TAP_SLOW 4'd10
`define TU_TAP_MID 4'd6
`define TU_TAP_FAST 4'd2
`endif

// ---- common/timer_unit_pkg.sv ----
// Types shared by the timer/counter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package timer_unit_pkg;
    typedef enum logic [1:0] {
        START_STOP = 2'h0,
        START_COMMAND = 2'h1,
        START_RISE = 2'h2,
        START_FALL = 2'h3
    } start_code_t;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_WINDOW = 2'h1,
        MODE_PULSE = 2'h2,
        MODE_PULSE_OUT = 2'h3
    } mode_code_t;
    typedef enum logic [1:0] {
        CLK_SLOW = 2'h0,
        CLK_MID = 2'h1,
        CLK_FAST = 2'h2,
        CLK_PIN = 2'h3
    } clock_code_t;
endpackage

// ---- common/source_tick_if.sv ----
// Carries source-clock selection and the resulting ticks and pin events.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface source_tick_if;
    import timer_unit_pkg::*;
    clock_code_t clockSel;
    logic prescaleFlag;
    logic countFalling;
    logic tick;
    logic pinLevel;
    logic pinRise;
    logic pinFall;
    modport gen (input clockSel, prescaleFlag, countFalling,
                 output tick, pinLevel, pinRise, pinFall);
    modport user (output clockSel, prescaleFlag, countFalling,
                  input tick, pinLevel, pinRise, pinFall);
endinterface
`default_nettype wire

// ---- verilog/source_tick_gen.sv ----
// Source clock tick generator: prescaler taps and the timer input pin.
// Assumes clk is the high-frequency clock and the pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_params.svh"
module source_tick_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timerPin,
    source_tick_if.gen tickBus
);
    import timer_unit_pkg::*;
    logic [`TU_PRESCALE_W-1:0] prescale_r;
    logic pinMeta_r;
    logic pinSync_r;
    logic pinPrev_r;
    logic tapPrev_r;
    logic [3:0] tapBase;
    logic [3:0] tapIdx;
    logic tapBit;
    logic pinEdge;

    assign tapBase = (tickBus.clockSel == CLK_SLOW) ? `TU_TAP_SLOW :
                     (tickBus.clockSel == CLK_MID) ? `TU_TAP_MID : `TU_TAP_FAST;
    assign tapIdx = tapBase + {3'h0, tickBus.prescaleFlag};
    assign tapBit = prescale_r[tapIdx];
    assign tickBus.pinLevel = pinSync_r;
    assign tickBus.pinRise = pinSync_r & ~pinPrev_r;
    assign tickBus.pinFall = ~pinSync_r & pinPrev_r;
    assign pinEdge = tickBus.countFalling ? tickBus.pinFall : tickBus.pinRise;
    // A tick marks the rising edge of the chosen prescaler tap, or the pin edge picked by countFalling.
    assign tickBus.tick = (tickBus.clockSel == CLK_PIN) ? pinEdge :
                          (tapBit & ~tapPrev_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= '0;
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinPrev_r <= 1'b0;
            tapPrev_r <= 1'b0;
        end else begin
            prescale_r <= prescale_r + 1'b1;
            pinMeta_r <= timerPin;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
            tapPrev_r <= tapBit;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/timer_unit_one.sv ----
// Control and register section of a 16-bit timer/counter on AHB-Lite.
// Assumes a single AHB-Lite master issuing single word transfers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_params.svh"
// Contract
// - One 8-bit control register plus compare and capture/duty 16-bit registers.
// - Each timer register stages written bytes apart from the effective value.
// - Staged value takes effect at first source tick after upper byte write.
// - Writing only the lower byte never changes the effective value.
// - Control register resets to zero: stopped, all fields zero.
// - Start code 00 stops; 01 command start in timer and pulse-output only.
// - While start code is 00 the counter is held cleared.
// - Clock select picks prescaler taps or pin; prescale flag doubles divisors.
// - Mode field: timer/trigger/event, window, pulse width, pulse output.
// - Bit 6 enables auto-capture in timer, event and window modes.
// - Bit 6 selects trigger stop, or one-shot in pulse-output mode.
// - Stop-mode entry forces start code 00 and halts the counter.
// - Auto-capture copies the counter into the capture register on ticks.
module timer_unit_one #(
    parameter int COUNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timerPin,
    input wire logic systemPrescaleFlag,
    input wire logic stopModeEntry,
    output logic matchPulse,
    output logic pulseOut,
    output logic counterRunning
);
    import timer_unit_pkg::*;

    source_tick_if tickBus ();

    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] dataIdx_r;
    logic dataWrite_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic [7:0] cmpLo_r;
    logic [7:0] cmpHi_r;
    logic [7:0] capLo_r;
    logic [7:0] capHi_r;
    logic cmpPending_r;
    logic capPending_r;
    logic [COUNT_W-1:0] cmpEff_r;
    logic [COUNT_W-1:0] capEff_r;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic armed_r;
    logic halted_r;
    logic flipflop_r;
    logic match_r;
    logic running_r;

    // Bus decode.
    wire addrPhase = hsel & htrans[1] & hready;
    wire [7:0] addrIdx = haddr[9:2];
    wire wrCtrl = dataWrite_r & (dataIdx_r == `TU_IDX_CTRL);
    wire wrCmpLo = dataWrite_r & (dataIdx_r == `TU_IDX_CMP_LO);
    wire wrCmpHi = dataWrite_r & (dataIdx_r == `TU_IDX_CMP_HI);
    wire ppgMode = mode_code_t'(ctrl_r[`TU_MODE_HI:`TU_MODE_LO]) == MODE_PULSE_OUT;
    wire wrCapLo = dataWrite_r & (dataIdx_r == `TU_IDX_CAP_LO) & ppgMode;
    wire wrCapHi = dataWrite_r & (dataIdx_r == `TU_IDX_CAP_HI) & ppgMode;

    // Control field decode.
    wire [1:0] startField = ctrl_r[`TU_START_HI:`TU_START_LO];
    wire [1:0] clockField = ctrl_r[`TU_CLK_HI:`TU_CLK_LO];
    wire [1:0] modeField = ctrl_r[`TU_MODE_HI:`TU_MODE_LO];
    wire option = ctrl_r[`TU_BIT_OPTION];
    wire stopped = start_code_t'(startField) == START_STOP;
    wire timerMode = mode_code_t'(modeField) == MODE_TIMER;
    wire windowMode = mode_code_t'(modeField) == MODE_WINDOW;
    wire pulseMode = mode_code_t'(modeField) == MODE_PULSE;
    wire pinClock = clock_code_t'(clockField) == CLK_PIN;
    wire eventMode = timerMode & startField[1] & pinClock;
    wire triggerMode = timerMode & startField[1] & ~pinClock;
    wire autoCapture = option & (timerMode | windowMode);
    wire singleEdgeCapture = option & pulseMode;
    wire triggerStop = option & triggerMode;
    wire oneShot = option & ppgMode;

    // Start control: 01 only starts timer and pulse-output modes.
    wire commandRun = (start_code_t'(startField) == START_COMMAND)
                      & (timerMode | ppgMode);
    wire startEdge = startField[0] ? tickBus.pinFall : tickBus.pinRise;
    wire stopEdge = startField[0] ? tickBus.pinRise : tickBus.pinFall;
    wire windowOpen = startField[0] ? ~tickBus.pinLevel : tickBus.pinLevel;
    wire edgeArmed = startField[1] & (triggerMode | pulseMode | ppgMode);
    wire runNow = ~halted_r & (commandRun | eventMode
                  | (windowMode & startField[1] & windowOpen)
                  | (edgeArmed & armed_r));
    wire countTick = tickBus.tick & runNow;
    wire atMatch = countTick & (count_r == cmpEff_r);
    wire atDuty = countTick & ppgMode & (count_r == capEff_r);
    wire capTick = tickBus.tick & autoCapture & ~stopped;
    wire trigAbort = triggerStop & armed_r & stopEdge;

    assign tickBus.clockSel = clock_code_t'(clockField);
    assign tickBus.prescaleFlag = systemPrescaleFlag;
    assign tickBus.countFalling = startField[0];

    source_tick_gen tickGen (
        .clk(clk),
        .rst_n(rst_n),
        .timerPin(timerPin),
        .tickBus(tickBus)
    );

    // Control register: stop-mode entry overrides the start field of a software write.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrCtrl) begin
            ctrl_nxt = hwdata[7:0];
        end
        if (stopModeEntry) begin
            ctrl_nxt[`TU_START_HI:`TU_START_LO] = START_STOP;
        end
    end

    // Counter: cleared while stopped, cleared on compare match.
    always_comb begin
        count_nxt = count_r;
        if (stopped || trigAbort) begin
            count_nxt = '0;
        end else if (atMatch) begin
            count_nxt = '0;
        end else if (countTick) begin
            count_nxt = count_r + 1'b1;
        end
    end

    // Read mux; the capture register is always readable.
    always_comb begin
        hrdata_nxt = 32'h0000_0000;
        case (addrIdx)
            `TU_IDX_CTRL: hrdata_nxt[7:0] = ctrl_r;
            `TU_IDX_CMP_LO: hrdata_nxt[COUNT_W-1:0] = cmpEff_r;
            `TU_IDX_CMP_HI: hrdata_nxt[7:0] = cmpEff_r[15:8];
            `TU_IDX_CAP_LO: hrdata_nxt[COUNT_W-1:0] = capEff_r;
            `TU_IDX_CAP_HI: hrdata_nxt[7:0] = capEff_r[15:8];
            `TU_IDX_STATUS: hrdata_nxt[7:0] = {singleEdgeCapture, oneShot, triggerStop,
                autoCapture, capPending_r, cmpPending_r, halted_r, running_r};
            default: hrdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataIdx_r <= 8'h00;
            dataWrite_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            dataWrite_r <= addrPhase & hwrite;
            if (addrPhase) begin
                dataIdx_r <= addrIdx;
                hrdata_r <= hrdata_nxt;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `TU_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Staging bytes; a pending flag set by a new upper write wins over the commit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpLo_r <= 8'hFF;
            cmpHi_r <= 8'hFF;
            capLo_r <= 8'hFF;
            capHi_r <= 8'hFF;
            cmpPending_r <= 1'b0;
            capPending_r <= 1'b0;
        end else begin
            if (wrCmpLo) cmpLo_r <= hwdata[7:0];
            if (wrCmpHi) cmpHi_r <= hwdata[7:0];
            if (wrCapLo) capLo_r <= hwdata[7:0];
            if (wrCapHi) capHi_r <= hwdata[7:0];
            cmpPending_r <= wrCmpHi | (cmpPending_r & ~tickBus.tick);
            capPending_r <= wrCapHi | (capPending_r & ~tickBus.tick);
        end
    end

    // Effective values move only on a source tick.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpEff_r <= `TU_TIMER_RESET;
            capEff_r <= `TU_TIMER_RESET;
        end else begin
            if (cmpPending_r && tickBus.tick) cmpEff_r <= {cmpHi_r, cmpLo_r};
            if (capTick) begin
                capEff_r <= count_r;
            end else if (capPending_r && tickBus.tick) begin
                capEff_r <= {capHi_r, capLo_r};
            end
        end
    end

    // Run state: edge arming, one-shot and trigger halts.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            armed_r <= 1'b0;
            halted_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            if (stopped) begin
                armed_r <= 1'b0;
                halted_r <= 1'b0;
            end else begin
                if (trigAbort || (atMatch && triggerMode)) armed_r <= 1'b0;
                else if (edgeArmed && startEdge) armed_r <= 1'b1;
                if (atMatch && oneShot) halted_r <= 1'b1;
            end
        end
    end

    // Pulse output follows the control bit while stopped and toggles at duty and period.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flipflop_r <= 1'b0;
            match_r <= 1'b0;
            running_r <= 1'b0;
        end else begin
            match_r <= atMatch;
            running_r <= runNow & ~stopped;
            if (stopped) flipflop_r <= ctrl_r[`TU_BIT_FLIPFLOP];
            else if (atMatch ^ atDuty) flipflop_r <= ~flipflop_r;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign matchPulse = match_r;
    assign pulseOut = flipflop_r;
    assign counterRunning = running_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_upper_write;
        wrCmpHi ##1 !tickBus.tick;
    endsequence
    sequence s_low_only;
        wrCmpLo && !cmpPending_r && !wrCmpHi;
    endsequence

    a_stop_clears_count: assert property (stopped |=> count_r == '0)
        else $error("Counter not cleared while stopped.");
    a_low_no_commit: assert property (s_low_only |=> $stable(cmpEff_r))
        else $error("Lower byte write changed the compare value.");
    a_upper_holds: assert property (s_upper_write |=> cmpPending_r && $stable(cmpEff_r))
        else $error("Compare value changed before a source tick.");
    a_tick_commits: assert property (cmpPending_r && tickBus.tick |=>
        cmpEff_r == {$past(cmpHi_r), $past(cmpLo_r)})
        else $error("Staged compare value not committed on tick.");
    a_cap_write_guard: assert property (dataWrite_r && dataIdx_r == `TU_IDX_CAP_LO
        && !ppgMode |=> $stable(capLo_r))
        else $error("Capture register accepted a write outside pulse output.");
    a_stop_entry: assert property (stopModeEntry |=> stopped ##1 count_r == '0)
        else $error("Stop-mode entry did not stop the counter.");
    a_auto_capture: assert property (capTick |=> capEff_r == $past(count_r))
        else $error("Auto-capture missed the counter value.");
    a_cmd_start_only: assert property (start_code_t'(startField) == START_COMMAND
        && (windowMode || pulseMode) && !$past(stopped) |=> $stable(count_r))
        else $error("Command start counted in an unsupported mode.");
    a_ctrl_readback: assert property (addrPhase && !hwrite && addrIdx == `TU_IDX_CTRL
        |=> hrdata == {24'h000000, $past(ctrl_r)})
        else $error("Control register read back wrong.");
    a_one_shot: assert property (atMatch && oneShot && !stopModeEntry && !wrCtrl
        |=> halted_r ##1 !countTick)
        else $error("One-shot did not halt after match.");
endmodule
`default_nettype wire

// ---- verification/pin_pulse_source.sv ----
// Model of the external pulse source that drives the timer input pin.
// Assumes the bench clock; pulse widths are counted in whole clock cycles.
`timescale 1ns/1ps
`default_nettype none
module pin_pulse_source (
    input wire logic clk,
    output logic timerPin
);
    // The pin rests low between bursts. Pulses are kept far wider than the
    // synchroniser and edge detector need, so that no edge is lost.
    task automatic send(input int count, input int width);
        for (int i = 0; i < count; i++) begin
            repeat (width) @(posedge clk);
            timerPin <= 1'b1;
            repeat (width) @(posedge clk);
            timerPin <= 1'b0;
        end
    endtask
    initial begin
        timerPin = 1'b0;
    end
endmodule
`default_nettype wire

// ---- verification/timer_unit_one_tb.sv ----
// Self-checking bench for the timer/counter register block on AHB-Lite.
// Assumes the register indices of the shared header and zero wait states.
`timescale 1ns/1ps
`default_nettype none
`include "timer_unit_params.svh"
module timer_unit_one_tb;
    import timer_unit_pkg::*;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, timerPin;
    logic prescale, stopModeEntry, matchPulse, pulseOut, counterRunning;
    logic [31:0] haddr, hwdata, hrdata, rd, rd2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int miscompares, comparisons, cycles, matchCount, g0, g1, n, k;
    assign hready = hreadyout;
    timer_unit_one #(.COUNT_W(16)) u_timer_unit_one (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timerPin(timerPin), .systemPrescaleFlag(prescale), .stopModeEntry(stopModeEntry),
        .matchPulse(matchPulse), .pulseOut(pulseOut), .counterRunning(counterRunning));
    pin_pulse_source u_pin_pulse_source (.clk(clk), .timerPin(timerPin));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (matchPulse === 1'b1) matchCount++;
        if (cycles == 30000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One single transfer; read data is taken at the edge that ends the data phase.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] data);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        data = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask
    task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] data;
        bus(1'b0, idx, 32'h0, data);
        check(data, exp, what);
    endtask
    // Low byte first, then high byte; the wait covers a few fast source ticks.
    task automatic set16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, {24'h0, v[7:0]});
        wr(lo + 8'h01, {24'h0, v[15:8]});
        repeat (40) @(posedge clk);
    endtask
    task automatic match_gap(output int gap);
        k = 0;
        while (matchPulse !== 1'b1 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        gap = 0;
        do begin
            @(posedge clk);
            gap++;
        end while (matchPulse !== 1'b1 && gap < 4000);
    endtask
    task automatic t_reset;
        rd_check(`TU_IDX_CTRL, 32'h0000_0000, "control after reset");
        rd_check(`TU_IDX_CMP_LO, 32'h0000_FFFF, "compare after reset");
        rd_check(8'h20, 32'h0000_0000, "unmapped read");
        check(32'({hresp, counterRunning}), 32'h0, "idle outputs");
    endtask
    task automatic t_staging;
        wr(`TU_IDX_CTRL, 32'h08);
        wr(`TU_IDX_CMP_LO, 32'h34);
        repeat (40) @(posedge clk);
        rd_check(`TU_IDX_CMP_LO, 32'h0000_FFFF, "low byte only");
        wr(`TU_IDX_CMP_HI, 32'h12);
        repeat (40) @(posedge clk);
        rd_check(`TU_IDX_CMP_LO, 32'h0000_1234, "compare commit");
        rd_check(`TU_IDX_CMP_HI, 32'h0000_0012, "compare high byte");
    endtask
    task automatic t_duty;
        set16(`TU_IDX_CAP_LO, 16'h0005);
        rd_check(`TU_IDX_CAP_LO, 32'h0000_FFFF, "duty write outside pulse output");
        wr(`TU_IDX_CTRL, 32'h0B);
        set16(`TU_IDX_CAP_LO, 16'h0005);
        rd_check(`TU_IDX_CAP_LO, 32'h0000_0005, "duty write in pulse output");
        wr(`TU_IDX_CTRL, 32'hCB);
        rd_check(`TU_IDX_CTRL, 32'h0000_00CB, "control read back");
        check(32'(pulseOut), 32'h1, "pulse output follows control bit");
        wr(`TU_IDX_CTRL, 32'h08);
        repeat (2) @(posedge clk);
        check(32'(pulseOut), 32'h0, "pulse output cleared");
    endtask
    task automatic t_fields;
        for (int m = 0; m < 4; m++) begin
            wr(`TU_IDX_CTRL, 32'h48 | m);
            rd_check(`TU_IDX_CTRL, 32'h48 | m, "mode field");
            bus(1'b0, `TU_IDX_STATUS, 32'h0, rd);
            check(32'(rd[7]), 32'(m == 2), "single edge decode");
            check(32'(rd[6]), 32'(m == 3), "one shot decode");
        end
        wr(`TU_IDX_CTRL, 32'h08);
    endtask
    task automatic t_count;
        set16(`TU_IDX_CMP_LO, 16'h0004);
        wr(`TU_IDX_CTRL, 32'h18);
        // The run flag is registered one edge after the control write lands.
        repeat (2) @(posedge clk);
        check(32'(counterRunning), 32'h1, "command start");
        match_gap(g0);
        check(32'(g0 % 8), 32'h0, "fast tap period");
        prescale <= 1'b1;
        match_gap(g1);
        match_gap(g1);
        check(32'(g1), 32'(2 * g0), "prescale doubles");
        prescale <= 1'b0;
        match_gap(g1);
        repeat (g0 / 2) @(posedge clk);
        wr(`TU_IDX_CTRL, 32'h08);
        repeat (2) @(posedge clk);
        check(32'(counterRunning), 32'h0, "stop code");
        repeat (50) @(posedge clk);
        wr(`TU_IDX_CTRL, 32'h18);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (matchPulse !== 1'b1 && n < 4000);
        check(32'(n >= g0 - 16), 32'h1, "counter cleared while stopped");
        stopModeEntry <= 1'b1;
        @(posedge clk);
        stopModeEntry <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(counterRunning), 32'h0, "stop mode halts");
        rd_check(`TU_IDX_CTRL, 32'h0000_0008, "stop mode clears start");
    endtask
    task automatic t_capture;
        set16(`TU_IDX_CMP_LO, 16'h1234);
        wr(`TU_IDX_CTRL, 32'h58);
        repeat (20) @(posedge clk);
        bus(1'b0, `TU_IDX_CAP_LO, 32'h0, rd);
        repeat (24) @(posedge clk);
        bus(1'b0, `TU_IDX_CAP_LO, 32'h0, rd2);
        check(32'(rd !== rd2), 32'h1, "capture follows counter");
        check(32'(rd2 < 32'h1234), 32'h1, "capture below compare");
        wr(`TU_IDX_CTRL, 32'h08);
    endtask
    task automatic t_pulse;
        wr(`TU_IDX_CTRL, 32'h0B);
        set16(`TU_IDX_CMP_LO, 16'h0006);
        set16(`TU_IDX_CAP_LO, 16'h0003);
        wr(`TU_IDX_CTRL, 32'h4B);
        k = matchCount;
        wr(`TU_IDX_CTRL, 32'h5B);
        repeat (200) @(posedge clk);
        check(32'(matchCount - k), 32'h1, "one shot single period");
        check(32'(counterRunning), 32'h0, "one shot halts");
        wr(`TU_IDX_CTRL, 32'h0B);
        wr(`TU_IDX_CTRL, 32'h1B);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pulseOut !== 1'b1 && n < 200);
        check(32'(n < 200), 32'h1, "pulse output toggles at duty");
        k = matchCount;
        repeat (200) @(posedge clk);
        check(32'(matchCount - k > 1), 32'h1, "continuous pulses");
        wr(`TU_IDX_CTRL, 32'h0B);
    endtask
    task automatic t_window;
        wr(`TU_IDX_CTRL, 32'h09);
        set16(`TU_IDX_CMP_LO, 16'h0003);
        wr(`TU_IDX_CTRL, 32'h19);
        repeat (40) @(posedge clk);
        check(32'(counterRunning), 32'h0, "no command start in window");
        wr(`TU_IDX_CTRL, 32'h09);
        wr(`TU_IDX_CTRL, 32'h29);
        k = matchCount;
        repeat (100) @(posedge clk);
        check(32'(matchCount), 32'(k), "window closed no count");
        u_pin_pulse_source.send(1, 150);
        repeat (20) @(posedge clk);
        check(32'(matchCount > k), 32'h1, "window open counts");
        wr(`TU_IDX_CTRL, 32'h09);
    endtask
    task automatic t_event;
        set16(`TU_IDX_CMP_LO, 16'h0003);
        wr(`TU_IDX_CTRL, 32'h0C);
        wr(`TU_IDX_CTRL, 32'h2C);
        k = matchCount;
        repeat (300) @(posedge clk);
        check(32'(matchCount), 32'(k), "no pin edges no count");
        u_pin_pulse_source.send(8, 8);
        repeat (20) @(posedge clk);
        check(32'(matchCount > k), 32'h1, "pin edges counted");
    endtask
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        prescale = 1'b0;
        stopModeEntry = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_staging();
        t_duty();
        t_fields();
        t_count();
        t_capture();
        t_pulse();
        t_window();
        t_event();
        end_of_test();
    end
endmodule
`default_nettype wire
